// ### inc/mpt_defines.vh
// Constants for the five-channel 16-bit PWM/capture timer.
// Included by rtl/mpt_timer.v; offsets are AXI4-Lite byte addresses.
`ifndef MPT_DEFINES_VH
`define MPT_DEFINES_VH

// Global registers
`define MPT_OFS_START 8'h00
`define MPT_OFS_SYNC 8'h04
`define MPT_OFS_MODE 8'h08
`define MPT_OFS_STAT 8'h0c
// Channel n occupies 8'h20*(n+1); word index inside the window
`define MPT_CH_BASE 3'h1
`define MPT_CH_LAST 3'h5
`define MPT_IDX_TCR 3'h0
`define MPT_IDX_IOC 3'h1
`define MPT_IDX_CNT 3'h2
`define MPT_IDX_GRA 3'h3
`define MPT_IDX_GRB 3'h4
`define MPT_IDX_BRA 3'h5
`define MPT_IDX_BRB 3'h6

// Mode register fields: [4:0] single-channel PWM per channel
`define MPT_MD_RSYNC 5
`define MPT_MD_COMP 6
`define MPT_MD_BUF3 7
`define MPT_MD_BUF4 8
`define MPT_MD_LS3 9
`define MPT_MD_LS4 10
`define MPT_MD_W 11

// Status fields: match A [4:0], match B [9:5], overflow [14:10]
`define MPT_ST_FA 0
`define MPT_ST_FB 5
`define MPT_ST_OV 10

// Counter clear source in timer_control_reg[1:0]
`define MPT_CLR_NONE 2'h0
`define MPT_CLR_A 2'h1
`define MPT_CLR_B 2'h2
`define MPT_CLR_SYNC 2'h3

// Capture edge in io_control_reg: [1:0] for A, [3:2] for B; 0 = compare
`define MPT_EDGE_OFF 2'h0
`define MPT_EDGE_RISE 2'h1
`define MPT_EDGE_FALL 2'h2
`define MPT_EDGE_BOTH 2'h3

// Reset values
`define MPT_CNT_RST 16'h0000
`define MPT_CMP_RST 16'hffff

// Capture pulse minimum in tenths of a system clock (10 ns each)
`define MPT_CAP_SINGLE_TENTHS 15
`define MPT_CAP_BOTH_TENTHS 25
`define MPT_CAP_SINGLE_CYC ((`MPT_CAP_SINGLE_TENTHS + 9) / 10)
`define MPT_CAP_BOTH_CYC ((`MPT_CAP_BOTH_TENTHS + 9) / 10)

// AXI responses
`define MPT_RESP_OK 2'h0
`define MPT_RESP_ERR 2'h2

`endif

// ### rtl/mpt_timer.v
// Five-channel 16-bit timer: capture, sync preset/clear, PWM, paired modes.
// Assumes one 10 MHz clock, synchronous reset, AXI4-Lite master outside.
`timescale 1ns/1ps
`include "mpt_defines.vh"

module mpt_timer (
   input wire core_clk, // 10 MHz system clock
   input wire srst, // synchronous reset, active high
   input wire [7:0] s_axi_awaddr, // write address
   input wire s_axi_awvalid, // write address valid
   output wire s_axi_awready, // write address ready
   input wire [31:0] s_axi_wdata, // write data
   input wire [3:0] s_axi_wstrb, // write byte enables
   input wire s_axi_wvalid, // write data valid
   output wire s_axi_wready, // write data ready
   output reg [1:0] s_axi_bresp, // write response
   output reg s_axi_bvalid, // write response valid
   input wire s_axi_bready, // write response ready
   input wire [7:0] s_axi_araddr, // read address
   input wire s_axi_arvalid, // read address valid
   output wire s_axi_arready, // read address ready
   output reg [31:0] s_axi_rdata, // read data
   output reg [1:0] s_axi_rresp, // read response
   output reg s_axi_rvalid, // read data valid
   input wire s_axi_rready, // read data ready
   input wire [4:0] capture_pin_a, // capture inputs A, asynchronous
   input wire [4:0] capture_pin_b, // capture inputs B, asynchronous
   output wire [4:0] waveform_pin_a, // waveform pins A
   output wire [4:0] waveform_pin_b, // waveform pins B
   output wire extra_out_pin_a, // complement of pair 2
   output wire extra_out_pin_b // complement of pair 3
);

   function [15:0] merge;
      input [15:0] old;
      input [31:0] nw;
      input [3:0] strb;
      begin
         merge = {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
      end
   endfunction

   function edge_hit;
      input [1:0] sel;
      input rise;
      input fall;
      begin
         edge_hit = (sel == `MPT_EDGE_RISE && rise) || (sel == `MPT_EDGE_FALL && fall) ||
            (sel == `MPT_EDGE_BOTH && (rise || fall));
      end
   endfunction

   reg [4:0] start;
   reg [4:0] sync;
   reg [`MPT_MD_W-1:0] mode;
   reg [14:0] stat;
   reg [1:0] timer_control_reg [0:4];
   reg [3:0] ioc [0:4];
   reg [15:0] cnt [0:4];
   reg [15:0] compare_reg_a [0:4];
   reg [15:0] compare_reg_b [0:4];
   reg [15:0] buffer_reg_a [0:4];
   reg [15:0] brb [0:4];
   reg [4:0] pwm_lvl;
   reg [2:0] pos;
   reg [2:0] neg;
   reg down;
   reg [4:0] a1, a2, a3, a_st;
   reg [4:0] b1, b2, b3, b_st;

   // AXI write side
   reg aw_held;
   reg w_held;
   reg [7:0] aw_addr;
   reg [31:0] w_data;
   reg [3:0] w_strb;
   wire [7:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr;
   wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
   wire [3:0] wr_strb = w_held ? w_strb : s_axi_wstrb;
   wire aw_ok = aw_held || s_axi_awvalid;
   wire w_ok = w_held || s_axi_wvalid;
   wire wr_go = aw_ok && w_ok && !s_axi_bvalid;
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;

   wire [2:0] wr_win = wr_addr[7:5];
   wire [2:0] wr_ch = wr_win - `MPT_CH_BASE;
   wire [2:0] wr_idx = wr_addr[4:2];
   wire wr_chan = wr_win >= `MPT_CH_BASE && wr_win <= `MPT_CH_LAST && wr_idx <= `MPT_IDX_BRB;
   wire wr_glob = wr_win == 3'h0 && wr_addr[4] == 1'b0;
   wire wr_map = (wr_chan || wr_glob) && wr_addr[1:0] == 2'h0;

   wire rsync = mode[`MPT_MD_RSYNC];
   wire comp = mode[`MPT_MD_COMP] && !rsync;
   wire paired = rsync || comp;

   // Edge detection and match events
   reg [4:0] rise_a, fall_a, rise_b, fall_b;
   reg [4:0] cap_a, cap_b, ma, mb, own_clr, clr;
   integer i;
   integer ch;
   always @* begin
      for (ch = 0; ch < 5; ch = ch + 1) begin
         rise_a[ch] = a2[ch] == a3[ch] && a3[ch] && !a_st[ch];
         fall_a[ch] = a2[ch] == a3[ch] && !a3[ch] && a_st[ch];
         rise_b[ch] = b2[ch] == b3[ch] && b3[ch] && !b_st[ch];
         fall_b[ch] = b2[ch] == b3[ch] && !b3[ch] && b_st[ch];
         // Capture also latches a stopped counter
         cap_a[ch] = !mode[ch] && edge_hit(ioc[ch][1:0], rise_a[ch], fall_a[ch]);
         cap_b[ch] = !mode[ch] && edge_hit(ioc[ch][3:2], rise_b[ch], fall_b[ch]);
         ma[ch] = start[ch] && (mode[ch] || ioc[ch][1:0] == `MPT_EDGE_OFF) &&
            cnt[ch] == compare_reg_a[ch];
         mb[ch] = start[ch] && (mode[ch] || ioc[ch][3:2] == `MPT_EDGE_OFF) &&
            cnt[ch] == compare_reg_b[ch];
         own_clr[ch] = (timer_control_reg[ch] == `MPT_CLR_A && (ma[ch] || cap_a[ch])) ||
            (timer_control_reg[ch] == `MPT_CLR_B && (mb[ch] || cap_b[ch]));
      end
      if (paired) begin
         own_clr[3] = 1'b0;
         own_clr[4] = 1'b0;
      end
      for (ch = 0; ch < 5; ch = ch + 1) begin
         clr[ch] = own_clr[ch] || (timer_control_reg[ch] == `MPT_CLR_SYNC && sync[ch] &&
            |(own_clr & sync));
      end
   end

   // Paired-mode points: pair 0 ch3 B, pair 1 ch4 A, pair 2 ch4 B
   wire [15:0] c3 = cnt[3];
   wire [15:0] c4 = cnt[4];
   wire [15:0] per3 = compare_reg_a[3];
   wire [2:0] hit3 = {c3 == compare_reg_b[4], c3 == compare_reg_a[4], c3 == compare_reg_b[3]};
   wire [2:0] hit4 = {c4 == compare_reg_b[4], c4 == compare_reg_a[4], c4 == compare_reg_b[3]};
   wire run3 = start[3];
   wire top = comp && run3 && !down && c3 == per3;
   wire bottom = comp && run3 && down && c4 == 16'h0000;
   wire rs_clr = rsync && run3 && c3 == per3;

   always @(posedge core_clk) begin
      if (srst) begin
         start <= 5'h00;
         sync <= 5'h00;
         mode <= {`MPT_MD_W{1'b0}};
         stat <= 15'h0000;
         for (i = 0; i < 5; i = i + 1) begin
            timer_control_reg[i] <= `MPT_CLR_NONE;
            ioc[i] <= 4'h0;
            cnt[i] <= `MPT_CNT_RST;
            compare_reg_a[i] <= `MPT_CMP_RST;
            compare_reg_b[i] <= `MPT_CMP_RST;
            buffer_reg_a[i] <= `MPT_CMP_RST;
            brb[i] <= `MPT_CMP_RST;
         end
         pwm_lvl <= 5'h00;
         pos <= 3'h0;
         neg <= 3'h7;
         down <= 1'b0;
         a1 <= 5'h00; a2 <= 5'h00; a3 <= 5'h00; a_st <= 5'h00;
         b1 <= 5'h00; b2 <= 5'h00; b3 <= 5'h00; b_st <= 5'h00;
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `MPT_RESP_OK;
      end else begin
         // Three-stage capture synchronisers
         a1 <= capture_pin_a;
         a2 <= a1;
         a3 <= a2;
         b1 <= capture_pin_b;
         b2 <= b1;
         b3 <= b2;
         for (i = 0; i < 5; i = i + 1) begin
            if (a2[i] == a3[i]) begin
               a_st[i] <= a3[i];
            end
            if (b2[i] == b3[i]) begin
               b_st[i] <= b3[i];
            end
         end

         // Independent channels (ch3/ch4 taken over below when paired)
         for (i = 0; i < 5; i = i + 1) begin
            if (start[i]) begin
               cnt[i] <= clr[i] ? 16'h0000 : cnt[i] + 16'h0001;
            end
            if (mode[i] && !(paired && i >= 3)) begin
               if (ma[i] && !mb[i]) begin
                  pwm_lvl[i] <= 1'b1;
               end else if (mb[i] && !ma[i]) begin
                  pwm_lvl[i] <= 1'b0;
               end
            end
            if (cap_a[i]) begin
               compare_reg_a[i] <= cnt[i];
               stat[`MPT_ST_FA + i] <= 1'b1;
            end
            if (cap_b[i]) begin
               compare_reg_b[i] <= cnt[i];
               stat[`MPT_ST_FB + i] <= 1'b1;
            end
         end
         // Buffering on ch3/ch4 outside paired modes
         for (i = 3; i < 5; i = i + 1) begin
            if (mode[`MPT_MD_BUF3 + i - 3] && !paired) begin
               if (cap_a[i]) begin
                  buffer_reg_a[i] <= compare_reg_a[i];
               end else if (ma[i]) begin
                  compare_reg_a[i] <= buffer_reg_a[i];
               end
               if (cap_b[i]) begin
                  brb[i] <= compare_reg_b[i];
               end else if (mb[i]) begin
                  compare_reg_b[i] <= brb[i];
               end
            end
         end

         // Reset-synchronized mode
         if (rsync && run3) begin
            stat[`MPT_ST_FA + 3] <= rs_clr ? 1'b1 : stat[`MPT_ST_FA + 3];
            stat[`MPT_ST_FB + 3] <= c3 == compare_reg_b[3] ? 1'b1 : stat[`MPT_ST_FB + 3];
            if (rs_clr) begin
               cnt[3] <= 16'h0000;
               pos <= 3'h7;
               neg <= 3'h0;
            end else begin
               cnt[3] <= c3 + 16'h0001;
               pos <= pos & ~hit3;
               neg <= neg | hit3;
            end
            if (rs_clr) begin
               if (mode[`MPT_MD_BUF3]) begin
                  compare_reg_b[3] <= brb[3];
               end
               if (mode[`MPT_MD_BUF4]) begin
                  compare_reg_a[4] <= buffer_reg_a[4];
                  compare_reg_b[4] <= brb[4];
               end
            end
         end
         if (rsync) begin
            // Channel 4 keeps counting freely, no compares
            cnt[4] <= start[4] ? c4 + 16'h0001 : c4;
         end

         // Complementary mode
         if (comp && run3) begin
            if (top) begin
               down <= 1'b1;
               stat[`MPT_ST_FA + 3] <= 1'b1;
            end else if (bottom) begin
               down <= 1'b0;
               stat[`MPT_ST_OV + 4] <= 1'b1;
            end
            // Old direction holds for the reversal cycle: overshoot, then undershoot
            if (down) begin
               cnt[3] <= c3 - 16'h0001;
               cnt[4] <= c4 - 16'h0001;
            end else begin
               cnt[3] <= c3 + 16'h0001;
               cnt[4] <= c4 + 16'h0001;
            end
            // Up: ch3 drops the complement, then ch4 raises the phase
            // Down: ch4 drops the phase, then ch3 raises the complement
            if (!down) begin
               neg <= neg & ~hit3;
               pos <= pos | hit4;
            end else begin
               pos <= pos & ~hit4;
               neg <= neg | hit3;
            end
            if (top || bottom) begin
               if (mode[`MPT_MD_BUF3]) begin
                  compare_reg_b[3] <= brb[3];
               end
               if (mode[`MPT_MD_BUF4]) begin
                  compare_reg_a[4] <= buffer_reg_a[4];
                  compare_reg_b[4] <= brb[4];
               end
            end
         end

         // Register writes; hardware-set flags win over clears
         if (aw_ok && !aw_held && !wr_go) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (w_ok && !w_held && !wr_go) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (wr_go) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_map ? `MPT_RESP_OK : `MPT_RESP_ERR;
            if (wr_map && wr_glob) begin
               case (wr_addr[3:2])
                  2'h0: start <= wr_strb[0] ? wr_data[4:0] : start;
                  2'h1: sync <= wr_strb[0] ? wr_data[4:0] : sync;
                  2'h2: begin
                     mode <= {wr_strb[1] ? wr_data[10:8] : mode[10:8],
                        wr_strb[0] ? wr_data[7:0] : mode[7:0]};
                     // A channel leaving PWM must not leave its pin high
                     pwm_lvl <= pwm_lvl & (wr_strb[0] ? wr_data[4:0] : mode[4:0]);
                     pos <= 3'h0;
                     neg <= 3'h7;
                     down <= 1'b0;
                  end
                  default: begin
                     // Write 1 clears; the sets below still win
                     stat <= stat & ~wr_data[14:0];
                  end
               endcase
            end
            if (wr_map && wr_chan) begin
               case (wr_idx)
                  `MPT_IDX_TCR: timer_control_reg[wr_ch] <= wr_strb[0] ? wr_data[1:0] : timer_control_reg[wr_ch];
                  `MPT_IDX_IOC: ioc[wr_ch] <= wr_strb[0] ? wr_data[3:0] : ioc[wr_ch];
                  `MPT_IDX_CNT: begin
                     cnt[wr_ch] <= merge(cnt[wr_ch], wr_data, wr_strb);
                     for (i = 0; i < 5; i = i + 1) begin
                        if (sync[i] && sync[wr_ch]) begin
                           cnt[i] <= merge(cnt[wr_ch], wr_data, wr_strb);
                        end
                     end
                  end
                  `MPT_IDX_GRA: compare_reg_a[wr_ch] <= merge(compare_reg_a[wr_ch], wr_data, wr_strb);
                  `MPT_IDX_GRB: compare_reg_b[wr_ch] <= merge(compare_reg_b[wr_ch], wr_data, wr_strb);
                  `MPT_IDX_BRA: buffer_reg_a[wr_ch] <= merge(buffer_reg_a[wr_ch], wr_data, wr_strb);
                  default: brb[wr_ch] <= merge(brb[wr_ch], wr_data, wr_strb);
               endcase
            end
         end
         // Flag sets repeated after the clear so a same-cycle event survives
         for (i = 0; i < 5; i = i + 1) begin
            if ((ma[i] && !(paired && i >= 3)) || cap_a[i] || (i == 3 && (top || rs_clr))) begin
               stat[`MPT_ST_FA + i] <= 1'b1;
            end
            if ((mb[i] && !(paired && i >= 3)) || cap_b[i] ||
                  (i == 3 && rsync && run3 && c3 == compare_reg_b[3])) begin
               stat[`MPT_ST_FB + i] <= 1'b1;
            end
            if (start[i] && !clr[i] && cnt[i] == 16'hffff && !(paired && i >= 3)) begin
               stat[`MPT_ST_OV + i] <= 1'b1;
            end
         end
         if (bottom) begin
            stat[`MPT_ST_OV + 4] <= 1'b1;
         end
      end
   end

   // Read side: one-cycle answer, registered data
   reg [31:0] rd_word;
   reg rd_map;
   wire [2:0] rd_win = s_axi_araddr[7:5];
   wire [2:0] rd_ch = rd_win - `MPT_CH_BASE;
   wire [2:0] rd_idx = s_axi_araddr[4:2];
   always @* begin
      rd_word = 32'h00000000;
      rd_map = s_axi_araddr[1:0] == 2'h0;
      if (rd_win == 3'h0 && s_axi_araddr[4] == 1'b0) begin
         case (s_axi_araddr[3:2])
            2'h0: rd_word = {27'h0, start};
            2'h1: rd_word = {27'h0, sync};
            2'h2: rd_word = {21'h0, mode};
            default: rd_word = {17'h0, stat};
         endcase
      end else if (rd_win >= `MPT_CH_BASE && rd_win <= `MPT_CH_LAST &&
            rd_idx <= `MPT_IDX_BRB) begin
         case (rd_idx)
            `MPT_IDX_TCR: rd_word = {30'h0, timer_control_reg[rd_ch]};
            `MPT_IDX_IOC: rd_word = {28'h0, ioc[rd_ch]};
            `MPT_IDX_CNT: rd_word = {16'h0, cnt[rd_ch]};
            `MPT_IDX_GRA: rd_word = {16'h0, compare_reg_a[rd_ch]};
            `MPT_IDX_GRB: rd_word = {16'h0, compare_reg_b[rd_ch]};
            `MPT_IDX_BRA: rd_word = {16'h0, buffer_reg_a[rd_ch]};
            default: rd_word = {16'h0, brb[rd_ch]};
         endcase
      end else begin
         rd_map = 1'b0;
      end
   end

   always @(posedge core_clk) begin
      if (srst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `MPT_RESP_OK;
      end else if (s_axi_arvalid && !s_axi_rvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_map ? rd_word : 32'h00000000;
         s_axi_rresp <= rd_map ? `MPT_RESP_OK : `MPT_RESP_ERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Pin mapping; pair states hold "active", level select gives polarity
   wire ls3 = mode[`MPT_MD_LS3];
   wire ls4 = mode[`MPT_MD_LS4];
   assign waveform_pin_a[2:0] = pwm_lvl[2:0];
   assign waveform_pin_a[3] = paired ? ~(pos[0] ^ ls3) : pwm_lvl[3];
   assign waveform_pin_a[4] = paired ? ~(pos[1] ^ ls4) : pwm_lvl[4];
   assign waveform_pin_b[2:0] = 3'h0;
   assign waveform_pin_b[3] = paired ? ~(neg[0] ^ ls3) : 1'b0;
   assign waveform_pin_b[4] = paired ? ~(pos[2] ^ ls4) : 1'b0;
   assign extra_out_pin_a = paired ? ~(neg[1] ^ ls4) : 1'b0;
   assign extra_out_pin_b = paired ? ~(neg[2] ^ ls4) : 1'b0;

endmodule // mpt_timer

// ### testbench/mpt_timer_asserts.sv
// Checker for the timer top ports: bus answers and paired-pin relations.
// Assumes the master offers write address and data in the same cycle.
`timescale 1ns/1ps
module mpt_timer_chk (
   input wire core_clk, // clock
   input wire srst, // reset
   input wire [7:0] s_axi_awaddr, // write addr
   input wire s_axi_awvalid, // aw valid
   input wire s_axi_awready, // aw ready
   input wire [31:0] s_axi_wdata, // write data
   input wire s_axi_wvalid, // w valid
   input wire s_axi_wready, // w ready
   input wire s_axi_bvalid, // b valid
   input wire s_axi_arvalid, // ar valid
   input wire s_axi_arready, // ar ready
   input wire s_axi_rvalid, // r valid
   input wire s_axi_rready, // r ready
   input wire [4:0] waveform_pin_a, // pins A
   input wire [4:0] waveform_pin_b, // pins B
   input wire extra_out_pin_a, // pair 2 complement
   input wire extra_out_pin_b // pair 3 complement
);
   logic [5:0] md;
   wire wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   // Shadow of mode bits [5:0], updated on the same edge as the design's copy
   always @(posedge core_clk) begin
      if (srst)
         md <= 6'h00;
      else if (wr && s_axi_awaddr == 8'h08)
         md <= s_axi_wdata[5:0];
   end
   pwm_off_a: assert property ((waveform_pin_a[2:0] & ~md[2:0]) == 3'h0)
      else $error("idle channel pin driven");
   pins_b_zero_a: assert property (waveform_pin_b[2:0] == 3'h0)
      else $error("unused pin b driven");
   pair_one_a: assert property (md[5] |-> waveform_pin_b[3] != waveform_pin_a[3])
      else $error("pair one not inverse");
   pair_two_a: assert property (md[5] |-> extra_out_pin_a != waveform_pin_a[4])
      else $error("pair two not inverse");
   pair_three_a: assert property (md[5] |-> extra_out_pin_b != waveform_pin_b[4])
      else $error("pair three not inverse");
   wr_resp_a: assert property (wr |=> s_axi_bvalid)
      else $error("write not answered");
   rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered");
   b_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while answering");
   cover property (wr);
   cover property (s_axi_rvalid && s_axi_rready);
   cover property (md[5] && $rose(waveform_pin_a[3]));
endmodule // mpt_timer_chk

bind mpt_timer mpt_timer_chk u_chk (.core_clk, .srst, .s_axi_awaddr, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .waveform_pin_a, .waveform_pin_b,
   .extra_out_pin_a, .extra_out_pin_b);

// ### testbench/mpt_cap_src.sv
// Capture signal source for the timer's capture pins.
// Follows requested levels but holds each level at least four clocks.
`timescale 1ns/1ps
module mpt_cap_src (
   input wire core_clk, // system clock
   input wire [4:0] want, // requested levels
   output logic [4:0] pin = 5'h00 // capture lines
);
   int held = 0;
   always @(posedge core_clk) begin
      held <= held + 1;
      if (want != pin && held >= 3) begin
         pin <= want;
         held <= 0;
      end
   end
endmodule // mpt_cap_src

// ### testbench/test_multichannel_pwm_timer_modes.sv
// Self-checking bench for the timer: registers, capture, sync, PWM duty.
// Assumes the checker is bound to the top and capture B is unused.
`timescale 1ns/1ps
module test_multichannel_pwm_timer_modes;
   logic core_clk = 0, srst = 1, aw_v = 0, w_v = 0, b_r = 0, ar_v = 0, r_r = 0;
   logic [7:0] aw_a = 8'h00, ar_a = 8'h00;
   logic [31:0] w_d = 32'h0;
   logic [4:0] want = 5'h00;
   wire [4:0] cap_a, pin_a, pin_b;
   wire aw_rdy, w_rdy, b_vld, ar_rdy, r_vld;
   wire [1:0] r_resp;
   wire [1:0] b_resp;
   wire [31:0] r_data;
   logic [33:0] rd_q[$];
   logic [1:0] wr_q[$];
   int duty_q[$];
   int miscompares = 0, checks_done = 0, hi_cnt = 0, duty_idx = 0, i;
   int tab[4][4] = '{'{4, 8, 2, 40}, '{10, 8, 2, 0}, '{8, 10, 1, 90}, '{5, 5, 2, 90}};
   logic [15:0] v, v2;
   logic win = 0, win_done = 0;
   initial forever #50 core_clk = ~core_clk;
   mpt_timer dut (.core_clk(core_clk), .srst(srst), .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v),
      .s_axi_awready(aw_rdy), .s_axi_wdata(w_d), .s_axi_wstrb(4'hf), .s_axi_wvalid(w_v),
      .s_axi_wready(w_rdy), .s_axi_bresp(b_resp), .s_axi_bvalid(b_vld), .s_axi_bready(b_r),
      .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_rdy), .s_axi_rdata(r_data),
      .s_axi_rresp(r_resp), .s_axi_rvalid(r_vld), .s_axi_rready(r_r), .capture_pin_a(cap_a),
      .capture_pin_b(5'h00), .waveform_pin_a(pin_a), .waveform_pin_b(pin_b),
      .extra_out_pin_a(), .extra_out_pin_b());
   mpt_cap_src u_src (.core_clk(core_clk), .want(want), .pin(cap_a));
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic note(input bit bad, input logic [33:0] e, input logic [33:0] a);
      checks_done++;
      if (bad) begin
         miscompares++;
         $display("ERROR %0t exp %h got %h", $time, e, a);
      end
   endtask
   task automatic cmp_rd(input logic [33:0] e, input logic [33:0] a);
      note(a !== e, e, a);
   endtask
   task automatic cmp_wr(input logic [1:0] e, input logic [1:0] a);
      note(a !== e, 34'(e), 34'(a));
   endtask
   task automatic cmp_duty(input int e, input int a);
      note(a != e, 34'(e), 34'(a));
   endtask
   task automatic stall;
      note(1, 34'h1, 34'h0);
      report_and_stop;
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = 2'h0);
      int n;
      n = 0;
      wr_q.push_back(e);
      aw_a <= a;
      w_d <= d;
      aw_v <= 1;
      w_v <= 1;
      b_r <= 1;
      do begin
         @(posedge core_clk);
         n++;
         if (aw_v && aw_rdy) aw_v <= 0;
         if (w_v && w_rdy) w_v <= 0;
      end while (!(b_vld && b_r) && n < 40);
      b_r <= 0;
      if (n >= 40) stall;
      @(posedge core_clk);
   endtask
   task automatic axr(input logic [7:0] a, input logic [33:0] e);
      int n;
      n = 0;
      rd_q.push_back(e);
      ar_a <= a;
      ar_v <= 1;
      r_r <= 1;
      do begin
         @(posedge core_clk);
         n++;
         if (ar_v && ar_rdy) ar_v <= 0;
      end while (!(r_vld && r_r) && n < 40);
      r_r <= 0;
      if (n >= 40) stall;
      @(posedge core_clk);
   endtask
   // Counts high cycles of one pin over 90 clocks, after 20 to settle
   task automatic duty(input int idx, input int e);
      duty_idx = idx;
      duty_q.push_back(e);
      repeat (20) @(posedge core_clk);
      win <= 1;
      repeat (90) @(posedge core_clk);
      win <= 0;
      win_done <= 1;
      @(posedge core_clk);
      win_done <= 0;
   endtask
   always @(posedge core_clk) begin
      if (r_vld && r_r) cmp_rd(rd_q.pop_front(), {r_resp, r_data});
      if (b_vld && b_r) cmp_wr(wr_q.pop_front(), b_resp);
      // An unknown pin level spoils the count instead of reading as low
      if (win && pin_a[duty_idx] !== 1'b0) hi_cnt += (pin_a[duty_idx] === 1'b1) ? 1 : 1000;
      if (win_done) begin
         cmp_duty(duty_q.pop_front(), hi_cnt);
         hi_cnt = 0;
      end
   end
   initial begin
      void'($urandom(56590));
      repeat (2) @(posedge core_clk);
      srst <= 0;
      @(posedge core_clk);
      axr(8'h2c, {2'h0, 32'hffff});
      axr(8'h28, 34'h0);
      axr(8'hfc, {2'h2, 32'h0});
      axw(8'hfc, 32'h0, 2'h2);
      $display("test reset values done");
      // Counter stays stopped so the captured value is known exactly
      for (i = 1; i < 4; i++) begin
         v = $urandom;
         v2 = $urandom;
         axw(8'h44, 32'(i));
         axw(8'h48, {16'h0, v});
         want <= 5'h02;
         repeat (8) @(posedge core_clk);
         axw(8'h48, {16'h0, v2});
         want <= 5'h00;
         repeat (8) @(posedge core_clk);
         axr(8'h4c, {18'h0, (i == 1) ? v : v2});
      end
      $display("test capture edges done");
      axw(8'h04, 32'h3);
      v = $urandom;
      axw(8'h28, {16'h0, v});
      axr(8'h48, {18'h0, v});
      axr(8'h68, 34'h0);
      $display("test sync preset done");
      axw(8'h08, 32'h1);
      for (i = 0; i < 4; i++) begin
         axw(8'h00, 0);
         axw(8'h28, 0);
         axw(8'h30, tab[i][1]);
         axw(8'h2c, tab[i][0]);
         axw(8'h20, tab[i][2]);
         axw(8'h00, 1);
         duty(0, tab[i][3]);
      end
      $display("test pwm duty done");
      axw(8'h00, 0);
      axw(8'h8c, 8);
      axw(8'h90, 4);
      axw(8'h88, 0);
      axw(8'h08, 32'h220);
      axw(8'h00, 32'h8);
      duty(3, 50);
      $display("test reset-sync done");
      axw(8'h00, 0);
      axw(8'h0c, 32'h7fff);
      axw(8'h08, 32'h240);
      axw(8'h88, 2);
      axw(8'ha8, 0);
      axw(8'h8c, 9);
      axw(8'h90, 5);
      axw(8'h00, 32'h18);
      duty(3, 30);
      axr(8'h0c, {2'h0, 32'h4008});
      $display("test complementary done");
      report_and_stop;
   end
endmodule // test_multichannel_pwm_timer_modes
